// ---- design/fegd_pkg.sv ----
// shared constants and carrier types for the flash erase host controller
package fegd_pkg;
  // command bytes and unlock addresses of the flash command set
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_READ_RESET = 8'hf0;
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h05555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h02aaa;
  // status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMER_BIT = 3;
  // sector select field of the address
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W = 3;
  // bus cycle timing at 250 MHz (4 ns period)
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 55;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // user-side request kinds
  typedef enum logic [1:0] {
    OP_ERASE_FIRST,
    OP_ERASE_ADD,
    OP_SUSPEND,
    OP_PROTECT
  } fegd_op_t;
  // user request carrier
  typedef struct packed {
    fegd_op_t op;
    logic [SECTOR_W-1:0] sector;
  } fegd_req_t;
  // user result carrier
  typedef struct packed {
    logic accepted;
    logic timerBefore;
    logic timerAfter;
    logic [7:0] status;
  } fegd_rsp_t;
endpackage

// ---- design/fegd_host.sv ----
// host controller that drives the flash pins for sector erase and sector protect
module fegd_host
  import fegd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // user side
  input wire logic reqValid,
  input fegd_req_t req,
  output logic reqReady,
  output logic rspValid,
  output fegd_rsp_t rsp,
  // flash pins
  output logic [18:0] flashAddr,
  output logic chipSelN,
  output logic writeStrobeN,
  output logic outEnN,
  output logic [7:0] dataOut,
  output logic dataOe_n,
  input wire logic [7:0] dataIn,
  // high voltage drive requests for oe and the id select address line
  output logic hvOutEn,
  output logic hvIdSelect
);
  // controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE_READ, ST_WRITE, ST_GAP, ST_POST_READ, ST_PROT, ST_DONE
  } fegd_state_t;

  fegd_state_t state_r, state_nxt; // sequencer state
  logic [CNT_W-1:0] cnt_r, cnt_nxt; // timing counter
  logic [2:0] step_r, step_nxt; // index into write sequence
  logic [2:0] last_r, last_nxt; // final step index of sequence
  fegd_req_t cur_r, cur_nxt; // request being served
  fegd_rsp_t rsp_r, rsp_nxt; // result being built
  logic [18:0] wAddr; // address of current write step
  logic [7:0] wData; // data of current write step
  logic [18:0] secAddr; // base address of chosen sector

  assign secAddr = {cur_r.sector, 16'h0000};

  // write sequence table: full six-cycle erase or single-cycle add/suspend
  always_comb begin
    wAddr = secAddr;
    wData = CMD_SECTOR_ERASE;
    if (cur_r.op == OP_SUSPEND) begin
      wData = CMD_SUSPEND;
    end else if (cur_r.op == OP_ERASE_FIRST) begin
      case (step_r)
        3'h0: begin wAddr = ADDR_UNLOCK1; wData = CMD_UNLOCK1; end
        3'h1: begin wAddr = ADDR_UNLOCK2; wData = CMD_UNLOCK2; end
        3'h2: begin wAddr = ADDR_UNLOCK1; wData = CMD_ERASE_SETUP; end
        3'h3: begin wAddr = ADDR_UNLOCK1; wData = CMD_UNLOCK1; end
        3'h4: begin wAddr = ADDR_UNLOCK2; wData = CMD_UNLOCK2; end
        default: begin wAddr = secAddr; wData = CMD_SECTOR_ERASE; end
      endcase
    end
  end

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    last_nxt = last_r;
    cur_nxt = cur_r;
    rsp_nxt = rsp_r;
    case (state_r)
      ST_IDLE: begin
        if (reqValid) begin
          cur_nxt = req;
          cnt_nxt = '0;
          step_nxt = '0;
          last_nxt = (req.op == OP_ERASE_FIRST) ? 3'h5 : 3'h0;
          rsp_nxt = '0;
          // sample timer flag before an added sector
          if (req.op == OP_ERASE_ADD) begin
            state_nxt = ST_PRE_READ;
          end else if (req.op == OP_PROTECT) begin
            state_nxt = ST_PROT;
          end else begin
            state_nxt = ST_WRITE;
          end
        end
      end
      ST_PRE_READ: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(READ_ACCESS_CYC)) begin
          rsp_nxt.timerBefore = dataIn[TIMER_BIT];
          cnt_nxt = '0;
          state_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // strobe held low for the pulse width
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WRITE_PULSE_CYC)) begin
          cnt_nxt = '0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WRITE_PULSE_CYC)) begin
          cnt_nxt = '0;
          if (step_r == last_r) begin
            state_nxt = ST_POST_READ;
          end else begin
            step_nxt = step_r + 1'b1;
            state_nxt = ST_WRITE;
          end
        end
      end
      ST_POST_READ: begin
        // status read from the erased sector
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(READ_ACCESS_CYC)) begin
          rsp_nxt.status = dataIn;
          rsp_nxt.timerAfter = dataIn[TIMER_BIT];
          // high after the add means maybe refused
          rsp_nxt.accepted = !(cur_r.op == OP_ERASE_ADD && dataIn[TIMER_BIT]);
          state_nxt = ST_DONE;
        end
      end
      ST_PROT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WRITE_PULSE_CYC)) begin
          rsp_nxt.accepted = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      step_r <= '0;
      last_r <= '0;
      cur_r <= '0;
      rsp_r <= '0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      last_r <= last_nxt;
      cur_r <= cur_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  logic wrPhase; // strobe low phase
  logic rdPhase; // read phase
  assign wrPhase = (state_r == ST_WRITE) || (state_r == ST_PROT);
  assign rdPhase = (state_r == ST_PRE_READ) || (state_r == ST_POST_READ);

  // pin drive registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flashAddr <= '0;
      chipSelN <= 1'b1;
      writeStrobeN <= 1'b1;
      outEnN <= 1'b1;
      dataOut <= '0;
      dataOe_n <= 1'b1;
      hvOutEn <= 1'b0;
      hvIdSelect <= 1'b0;
    end else if (clkEn) begin
      flashAddr <= rdPhase ? secAddr : wAddr;
      // write only with oe high, select and strobe low
      chipSelN <= !(wrPhase || rdPhase || state_r == ST_GAP);
      writeStrobeN <= !wrPhase;
      outEnN <= !(rdPhase && state_r != ST_PROT);
      dataOut <= wData;
      dataOe_n <= !(state_r == ST_WRITE || state_r == ST_GAP);
      // high voltage on oe and id line during protect
      hvOutEn <= (state_r == ST_PROT);
      hvIdSelect <= (state_r == ST_PROT);
    end
  end

  assign reqReady = (state_r == ST_IDLE);
  assign rspValid = (state_r == ST_DONE);
  assign rsp = rsp_r;

  // strobe never low with oe low unless high voltage is on oe
  chk_write_oe_high: assert property (@(posedge clk) disable iff (rst)
    !writeStrobeN |-> outEnN || hvOutEn) else $error("write strobe with output enable low");
  // protect has id line high voltage on when the strobe falls with high voltage on oe
  chk_prot_hv: assert property (@(posedge clk) disable iff (rst)
    $fell(writeStrobeN) && hvOutEn |-> hvIdSelect) else $error("protect without id line high voltage");
  // protect pulse ends within bounded time
  chk_prot_end: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_PROT) && clkEn |-> ##[1:40] state_r != ST_PROT) else $error("protect pulse too long");
  // full erase sequence writes six steps
  chk_erase_len: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_IDLE && reqValid && req.op == OP_ERASE_FIRST && clkEn |=> last_r == 3'h5)
    else $error("erase sequence length wrong");
endmodule

// ---- testbench/fegd_flash_model.sv ----
// behavioural flash device answering the host controller
module fegd_flash_model
  import fegd_pkg::*;
#(
  parameter int WINDOW_NS = 2000,
  parameter int ERASE_NS = 4000
)(
  input wire logic [18:0] addr,
  input wire logic chipSelN,
  input wire logic writeStrobeN,
  input wire logic outEnN,
  input wire logic [7:0] wrData,
  input wire logic hvOutEn,
  input wire logic hvIdSelect,
  input wire logic lockout,
  output logic [7:0] rdData = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  int step = 0;
  logic winOpen = 0; // erase time-out window open
  logic busy = 0; // internal erase running
  logic tog = 0; // toggle status bit state
  logic armed = 0; // strobe seen falling since power-up
  logic [7:0] prot = 8'h00; // protected sectors
  logic [7:0] stat; // value driven on reads
  logic [7:0] lastRd = 8'h00; // last value driven while selected
  time t0 = 0; // start of window or erase
  function automatic logic seqOk(int s, logic [18:0] a, logic [7:0] d);
    case (s)
      0, 3: return a == ADDR_UNLOCK1 && d == CMD_UNLOCK1;
      1, 4: return a == ADDR_UNLOCK2 && d == CMD_UNLOCK2;
      2: return a == ADDR_UNLOCK1 && d == CMD_ERASE_SETUP;
      default: return d == CMD_SECTOR_ERASE;
    endcase
  endfunction
  always @(negedge writeStrobeN) begin
    armed = 1;
    if (hvOutEn && hvIdSelect && !chipSelN) prot[addr[18:16]] = 1;
  end
  always @(posedge writeStrobeN) begin
    if (armed && !chipSelN && outEnN && !lockout && !hvOutEn && !busy) begin
      if (winOpen && wrData != CMD_SECTOR_ERASE) begin
        winOpen = 0;
        step = 0;
      end else if (winOpen) begin
        step = 0;
      end else if (!seqOk(step, addr, wrData)) begin
        step = 0;
      end else if (step < 5) begin
        step++;
      end else begin
        step = 0;
        winOpen = !prot[addr[18:16]];
        t0 = $time;
      end
    end
  end
  always #4 begin
    if (winOpen && $time - t0 >= WINDOW_NS) begin
      winOpen = 0;
      busy = 1;
      t0 = $time;
    end
    if (busy && $time - t0 >= ERASE_NS) busy = 0;
    if (lockout) begin
      winOpen = 0;
      busy = 0;
      step = 0;
    end
  end
  // toggle on each read while active
  always @(negedge outEnN) if (!chipSelN) tog = ~tog;
  always @* begin
    stat = (winOpen || busy) ? 8'h00 : 8'hff;
    if (winOpen || busy) stat[TOGGLE_BIT] = tog;
    stat[TIMER_BIT] = busy || !winOpen;
  end
  // released bus shows the inverse of the last driven value, held steady
  always @(chipSelN, outEnN, stat) begin
    if (!chipSelN && !outEnN) begin
      lastRd = stat;
      rdData = stat;
    end else begin
      rdData = ~lastRd;
    end
  end
endmodule

// ---- testbench/flash_erase_window_and_write_guard_tb_top.sv ----
// self-checking bench for the flash erase host controller
module flash_erase_window_and_write_guard_tb_top;
  import fegd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin failCount++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
  typedef struct {fegd_op_t op; int sec; int waitCyc; logic [1:0] mask; logic acc; logic tb; logic poll;} fegd_row_t;
  logic clk = 0, rst = 1, reqValid = 0, lockout = 0;
  fegd_req_t req = '0;
  logic reqReady, rspValid, chipSelN, writeStrobeN, outEnN, dataOe_n, hvOutEn, hvIdSelect;
  fegd_rsp_t rsp;
  logic [18:0] flashAddr;
  logic [7:0] dataOut, rdData;
  wire logic [7:0] flashData = dataOe_n ? rdData : dataOut;
  int failCount = 0, nTests = 0;
  fegd_row_t rows[7] = '{'{OP_ERASE_FIRST, 0, 0, 2'b01, 0, 0, 0}, '{OP_ERASE_ADD, 1, 0, 2'b11, 1, 0, 0},
    '{OP_ERASE_ADD, 2, 700, 2'b10, 0, 1, 0}, '{OP_PROTECT, 3, 1200, 2'b11, 1, 0, 0},
    '{OP_ERASE_FIRST, 3, 0, 2'b01, 0, 0, 1}, '{OP_ERASE_FIRST, 4, 0, 2'b01, 0, 0, 0},
    '{OP_SUSPEND, 0, 0, 2'b01, 0, 0, 1}};
  always #2 clk = ~clk;
  fegd_host uut (.clk(clk), .rst(rst), .clkEn(1'b1), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rsp(rsp), .flashAddr(flashAddr), .chipSelN(chipSelN), .writeStrobeN(writeStrobeN),
    .outEnN(outEnN), .dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(flashData), .hvOutEn(hvOutEn),
    .hvIdSelect(hvIdSelect));
  fegd_flash_model dev (.addr(flashAddr), .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .outEnN(outEnN),
    .wrData(flashData), .hvOutEn(hvOutEn), .hvIdSelect(hvIdSelect), .lockout(lockout), .rdData(rdData));
  // one request, held until taken, then wait for the answer
  task automatic doReq(fegd_op_t op, int sec);
    int i;
    @(posedge clk) #1;
    reqValid = 1;
    req = '{op: op, sector: sec[SECTOR_W-1:0]};
    for (i = 0; i < 50 && reqReady !== 1'b1; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    reqValid = 0;
    for (i = 0; i < 400 && rspValid !== 1'b1; i++) @(posedge clk) #1;
    `CHK(rspValid, 1'b1)
  endtask
  task automatic summarize();
    if (failCount == 0 && nTests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #80000;
    failCount++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    `CHK({reqReady, rspValid, chipSelN, writeStrobeN, hvOutEn}, 5'h16)
    rst = 0;
    foreach (rows[k]) begin
      repeat (rows[k].waitCyc) @(posedge clk);
      doReq(rows[k].op, rows[k].sec);
      if (rows[k].mask[0]) `CHK(rsp.status[POLL_BIT], rows[k].poll)
      if (rows[k].mask[1]) `CHK(rsp.timerBefore, rows[k].tb)
      if (rows[k].mask[0] && rows[k].mask[1]) `CHK(rsp.accepted, rows[k].acc)
    end
    // lockout makes the device ignore a full erase sequence
    lockout = 1;
    doReq(OP_ERASE_FIRST, 6);
    `CHK(rsp.status[POLL_BIT], 1'b1)
    lockout = 0;
    summarize();
  end
endmodule
